/* test/pss_supply_config_test.sv */
// Self-checking bench of the power state supply configuration block
module pss_supply_config_test;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {logic [31:0] data; logic err;} pss_note_t;

   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic sleepReq = 1'b0;
   logic wakeReq = 1'b0;
   logic fault = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, coreGood, pllGood;
   logic coreConvEnable, analogConvEnable, coreConvPfm, analogConvPfm;
   logic ioSupplyEnable, pllRegEnable, tileClockGate;
   logic [2:0] seqState;
   logic [2:0] prevState = 3'h0;
   logic [31:0] rnd = 32'h39b1;
   logic [31:0] expAwake = 32'h0000_0033;
   logic [31:0] expS1 = 32'h0010_0022;
   logic [31:0] expS2 = 32'h0010_0002;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   int quiet = 0;
   int dwell = 0;
   int goodRun = 0;
   pss_note_t notes[$];
   wire logic [6:0] outs = {tileClockGate, analogConvPfm, coreConvPfm, ioSupplyEnable,
      pllRegEnable, analogConvEnable, coreConvEnable};

   always #12.5 core_clk = ~core_clk;

   pss_supply_config #(.CW(32), .WAKE_LOG2(6)) pss_supply_config_inst (.core_clk(core_clk),
      .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepReq(sleepReq),
      .wakeReq(wakeReq), .coreGood(coreGood), .pllGood(pllGood),
      .coreConvEnable(coreConvEnable), .analogConvEnable(analogConvEnable),
      .coreConvPfm(coreConvPfm), .analogConvPfm(analogConvPfm),
      .ioSupplyEnable(ioSupplyEnable), .pllRegEnable(pllRegEnable),
      .tileClockGate(tileClockGate), .seqState(seqState));

   pss_supply_model pss_supply_model_inst (.core_clk(core_clk), .rst_n(rst_n),
      .coreConvEnable(coreConvEnable), .pllRegEnable(pllRegEnable), .fault(fault),
      .coreGood(coreGood), .pllGood(pllGood));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   function automatic logic [6:0] cfgOut(input logic [31:0] v);
      return {v[14], v[9], v[8], v[5], v[4], v[1], v[0]};
   endfunction : cfgOut

   function automatic logic [2:0] nextOf(input logic [2:0] p);
      if (p == 3'h0 || p == 3'h1) return 3'h2;
      if (p == 3'h7) return 3'h1;
      return p + 3'h1;
   endfunction : nextOf

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         fails++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask : check

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // Entered just after a rising edge; leaves one idle cycle behind it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic err);
      notes.push_back('{e, err});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] e;
      e = d & (a == 8'h18 ? pss_pkg::AWAKE_WR_MASK : pss_pkg::SLEEP_WR_MASK);
      e = e | pss_pkg::RO_ONE_MASK;
      apb(1'b1, a, d, 32'h0, 1'b0);
      if (a == 8'h18) expAwake = e;
      else if (a == 8'h1c) expS1 = e;
      else expS2 = e;
      apb(1'b0, a, 32'h0, e, 1'b0);
   endtask : wr

   task automatic wait_state(input logic [2:0] s);
      while (seqState !== s) @(posedge core_clk);
   endtask : wait_state

   // ****************************************
   // Output watcher
   // ****************************************
   always @(posedge core_clk) begin
      pss_note_t n;
      cycles++;
      if (cycles == 5000) begin
         fails++;
         end_sim();
      end
      quiet = psel ? 0 : quiet + 1;
      if (psel && penable && pready) begin
         n = notes.pop_front();
         if (!pwrite) check(prdata, n.data);
         check(pslverr, n.err);
      end
      if (!rst_n) begin
         prevState = 3'h0;
         dwell = 0;
      end else begin
         // Settings only judged once a write has had time to land
         if (quiet > 3 && (seqState == 3'h4 || seqState == 3'h5))
            check(outs, cfgOut(expAwake));
         if (quiet > 3 && seqState == 3'h6) check(outs, cfgOut(expS1));
         if (quiet > 3 && seqState == 3'h7) check(outs, cfgOut(expS2));
         if (seqState !== prevState) begin
            check(seqState, nextOf(prevState));
            if (prevState == 3'h6) check(dwell, 1 << expS1[20:16]);
            if (prevState == 3'h7) check(dwell, 1 << expS2[20:16]);
            if (prevState == 3'h3) check(goodRun >= 2, 1);
            dwell = 1;
         end else begin
            dwell++;
         end
         prevState = seqState;
      end
      goodRun = (coreGood && pllGood) ? goodRun + 1 : 0;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      apb(1'b0, 8'h18, 32'h0, 32'h0000_0033, 1'b0);
      apb(1'b0, 8'h1c, 32'h0, 32'h0010_0022, 1'b0);
      apb(1'b0, 8'h20, 32'h0, 32'h0010_0002, 1'b0);
      apb(1'b0, 8'h04, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h28, rnd, 32'h0, 1'b1);
      sleepReq <= 1'b1;
      repeat (8) @(posedge core_clk);
      check(seqState, 3'h2);
      sleepReq <= 1'b0;
      wr(8'h18, 32'hffff_ffff);
      rnd = xorshift(rnd);
      wr(8'h1c, {rnd[31:21], 3'b000, rnd[17:0]});
      rnd = xorshift(rnd);
      wr(8'h20, rnd & 32'hffe0_ffff);
      // Supplies held bad past the waking dwell: sequencer must wait
      wait_state(3'h3);
      fault <= 1'b1;
      repeat (200) @(posedge core_clk);
      check(seqState, 3'h3);
      fault <= 1'b0;
      repeat (20) @(posedge core_clk);
      check(seqState, 3'h5);
      for (int i = 0; i < 4; i++) begin
         rnd = xorshift(rnd);
         wr(8'h18, rnd);
         repeat (6) @(posedge core_clk);
      end
      wakeReq <= 1'b1;
      repeat (8) @(posedge core_clk);
      check(seqState, 3'h5);
      wakeReq <= 1'b0;
      sleepReq <= 1'b1;
      wait_state(3'h6);
      sleepReq <= 1'b0;
      wait_state(3'h1);
      repeat (4) @(posedge core_clk);
      wakeReq <= 1'b1;
      repeat (8) @(posedge core_clk);
      check(seqState, 3'h2);
      wakeReq <= 1'b0;
      end_sim();
   end
endmodule : pss_supply_config_test

/* test/pss_supply_model.sv */
// Behavioural model of the supplies switched by the sequencer
module pss_supply_model #(
   parameter int RAMP = 4
) (
   input wire logic core_clk, // Controller clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic coreConvEnable, // Core converter on
   input wire logic pllRegEnable, // PLL regulator on
   input wire logic fault, // Holds both goods low
   output logic coreGood, // Core supply good
   output logic pllGood // PLL supply good
);
   timeunit 1ns;
   timeprecision 1ps;

   int coreCnt = 0;
   int pllCnt = 0;

   // Good only after a ramp, and lost at once when switched off
   always @(posedge core_clk) begin
      coreCnt <= (!rst_n || !coreConvEnable) ? 0 : coreCnt + (coreCnt < RAMP);
      pllCnt <= (!rst_n || !pllRegEnable) ? 0 : pllCnt + (pllCnt < RAMP);
   end

   assign coreGood = !fault && coreCnt >= RAMP;
   assign pllGood = !fault && pllCnt >= RAMP;
endmodule : pss_supply_model

/* verilog/pss_dwell_timer.sv */
// Dwell timer holding a state for two to the power N clock cycles
module pss_dwell_timer #(
   parameter int CW = 32,
   parameter int LW = 5
) (
   input wire logic core_clk, // Controller clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic restart, // Clear count on state entry
   input wire logic [LW-1:0] log2Cycles, // Dwell exponent
   output logic expired // High from the last cycle of the dwell until restart
);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] limit;

   // Count 0 is the first cycle of the state, so the last is 2^N - 1
   assign limit = (CW'(1) << log2Cycles) - CW'(1);
   assign expired = (cnt_reg == limit);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (restart) begin
         cnt_reg <= '0;
      end else if (!expired) begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end

endmodule : pss_dwell_timer

/* verilog/pss_pkg.sv */
// Constants, register map and state type of the power state supply configuration block
package pss_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] AWAKE_CFG_OFS = 8'h18;
   localparam logic [7:0] SLEEP1_CFG_OFS = 8'h1c;
   localparam logic [7:0] SLEEP2_CFG_OFS = 8'h20;
   localparam logic [7:0] STATUS_OFS = 8'h24;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int TILE_GATE_BIT = 14;
   localparam int ANA_PFM_BIT = 9;
   localparam int CORE_PFM_BIT = 8;
   localparam int IO_EN_BIT = 5;
   localparam int PLL_EN_BIT = 4;
   localparam int ANA_EN_BIT = 1;
   localparam int CORE_EN_BIT = 0;
   localparam int DWELL_LSB = 16;
   localparam int DWELL_W = 5;
   localparam int STATE_LSB = 16;
   localparam int STATE_W = 3;

   // ****************************************
   // Masks and reset values
   // ****************************************
   localparam logic [31:0] AWAKE_WR_MASK = 32'h0000_4331;
   localparam logic [31:0] SLEEP_WR_MASK = 32'h001f_4331;
   localparam logic [31:0] RO_ONE_MASK = 32'h0000_0002;
   localparam logic [31:0] OUT_MASK = 32'h0000_4333;
   localparam logic [31:0] AWAKE_RST = 32'h0000_0031;
   localparam logic [31:0] SLEEP1_RST = 32'h0010_0020;
   localparam logic [31:0] SLEEP2_RST = 32'h0010_0000;

   // Fixed settings of the states without a register here
   localparam logic [31:0] RESET_CFG = 32'h0000_0000;
   localparam logic [31:0] ASLEEP_CFG = 32'h0010_0000;
   localparam logic [31:0] WAKE1_CFG = 32'h0010_0020;
   localparam logic [31:0] WAKE2_CFG = 32'h0010_0033;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      ST_RESET,
      ST_ASLEEP,
      ST_WAKING1,
      ST_WAKING2,
      ST_AWAKE_WAIT,
      ST_AWAKE,
      ST_SLEEP1,
      ST_SLEEP2
   } pss_state_t;

endpackage : pss_pkg

/* verilog/pss_supply_config.sv */
// Per-state supply configuration registers and the power state sequencer applying them

module pss_supply_config #(
   parameter int CW = 32,
   parameter int WAKE_LOG2 = 16
) (
   input wire logic core_clk, // Controller clock, 40 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic sleepReq, // Sleep request pin
   input wire logic wakeReq, // Wake request pin
   input wire logic coreGood, // Core supply good pin
   input wire logic pllGood, // PLL supply good pin
   output logic coreConvEnable, // Core switching converter enable
   output logic analogConvEnable, // Analogue switching converter enable
   output logic coreConvPfm, // Core converter in pulse frequency mode
   output logic analogConvPfm, // Analogue converter in pulse frequency mode
   output logic ioSupplyEnable, // IO supply output enable
   output logic pllRegEnable, // PLL linear regulator enable
   output logic tileClockGate, // Processor tile clock stopped
   output logic [2:0] seqState // Sequencer state code
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] syncA_reg;
   logic [3:0] syncB_reg;
   logic sleepReqS;
   logic wakeReqS;
   logic coreGoodS;
   logic pllGoodS;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         syncA_reg <= 4'h0;
         syncB_reg <= 4'h0;
      end else begin
         syncA_reg <= {pllGood, coreGood, wakeReq, sleepReq};
         syncB_reg <= syncA_reg;
      end
   end

   assign sleepReqS = syncB_reg[0];
   assign wakeReqS = syncB_reg[1];
   assign coreGoodS = syncB_reg[2];
   assign pllGoodS = syncB_reg[3];

   // ****************************************
   // APB slave
   // ****************************************
   logic [31:0] awakeCfg_reg;
   logic [31:0] sleep1Cfg_reg;
   logic [31:0] sleep2Cfg_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdNext;
   logic pready_reg;
   logic pslverr_reg;
   logic mapped;
   logic setup;
   logic access;
   logic wrOk;
   pss_pkg::pss_state_t stateReg;
   pss_pkg::pss_state_t stateNext;
   logic [31:0] cfgOut_reg;

   assign setup = psel && !penable;
   assign access = psel && penable && pready_reg;
   assign wrOk = access && pwrite && !pslverr_reg;

   always_comb begin
      mapped = 1'b1;
      rdNext = 32'h0;
      case (paddr)
         pss_pkg::AWAKE_CFG_OFS: begin
            rdNext = (awakeCfg_reg & pss_pkg::AWAKE_WR_MASK) | pss_pkg::RO_ONE_MASK;
         end
         pss_pkg::SLEEP1_CFG_OFS: begin
            rdNext = (sleep1Cfg_reg & pss_pkg::SLEEP_WR_MASK) | pss_pkg::RO_ONE_MASK;
         end
         pss_pkg::SLEEP2_CFG_OFS: begin
            rdNext = (sleep2Cfg_reg & pss_pkg::SLEEP_WR_MASK) | pss_pkg::RO_ONE_MASK;
         end
         pss_pkg::STATUS_OFS: begin
            rdNext = cfgOut_reg & pss_pkg::OUT_MASK;
            rdNext[pss_pkg::STATE_LSB +: pss_pkg::STATE_W] = stateReg;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // One wait-free access phase: answer prepared in the setup cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && !mapped;
         if (setup) begin
            prdata_reg <= pwrite ? 32'h0 : rdNext;
         end
      end
   end

   // Read-only and reserved bits are never stored
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         awakeCfg_reg <= pss_pkg::AWAKE_RST;
         sleep1Cfg_reg <= pss_pkg::SLEEP1_RST;
         sleep2Cfg_reg <= pss_pkg::SLEEP2_RST;
      end else if (wrOk) begin
         if (paddr == pss_pkg::AWAKE_CFG_OFS) begin
            awakeCfg_reg <= pwdata & pss_pkg::AWAKE_WR_MASK;
         end
         if (paddr == pss_pkg::SLEEP1_CFG_OFS) begin
            sleep1Cfg_reg <= pwdata & pss_pkg::SLEEP_WR_MASK;
         end
         if (paddr == pss_pkg::SLEEP2_CFG_OFS) begin
            sleep2Cfg_reg <= pwdata & pss_pkg::SLEEP_WR_MASK;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ****************************************
   // Sequencer
   // ****************************************
   logic [31:0] curCfg;
   logic [31:0] nextCfg;
   logic [pss_pkg::DWELL_W-1:0] dwellLog2;
   logic dwellDone;
   logic suppliesGood;
   logic restart;

   function automatic logic [31:0] cfgFor(input pss_pkg::pss_state_t s);
      logic [31:0] c;
      c = pss_pkg::RESET_CFG;
      case (s)
         pss_pkg::ST_ASLEEP: c = pss_pkg::ASLEEP_CFG;
         pss_pkg::ST_WAKING1: c = pss_pkg::WAKE1_CFG;
         pss_pkg::ST_WAKING2: c = pss_pkg::WAKE2_CFG;
         pss_pkg::ST_AWAKE_WAIT: c = awakeCfg_reg | pss_pkg::RO_ONE_MASK;
         pss_pkg::ST_AWAKE: c = awakeCfg_reg | pss_pkg::RO_ONE_MASK;
         pss_pkg::ST_SLEEP1: c = sleep1Cfg_reg | pss_pkg::RO_ONE_MASK;
         pss_pkg::ST_SLEEP2: c = sleep2Cfg_reg | pss_pkg::RO_ONE_MASK;
         default: c = pss_pkg::RESET_CFG;
      endcase
      return c;
   endfunction : cfgFor

   assign curCfg = cfgFor(stateReg);
   assign nextCfg = cfgFor(stateNext);
   // Awake has no dwell field; exponent 0 there is never consulted
   // Waking dwell is a parameter so short runs need not wait 2^16 cycles
   assign dwellLog2 = (stateReg == pss_pkg::ST_AWAKE) ? '0 :
      (stateReg inside {pss_pkg::ST_WAKING1, pss_pkg::ST_WAKING2}) ?
      pss_pkg::DWELL_W'(WAKE_LOG2) :
      curCfg[pss_pkg::DWELL_LSB +: pss_pkg::DWELL_W];
   // Only supplies enabled in this state must report good
   assign suppliesGood = (!curCfg[pss_pkg::CORE_EN_BIT] || coreGoodS) &&
      (!curCfg[pss_pkg::PLL_EN_BIT] || pllGoodS);
   assign restart = (stateNext != stateReg);

   always_comb begin
      stateNext = stateReg;
      case (stateReg)
         pss_pkg::ST_RESET: stateNext = pss_pkg::ST_WAKING1;
         pss_pkg::ST_ASLEEP: begin
            if (wakeReqS) begin
               stateNext = pss_pkg::ST_WAKING1;
            end
         end
         pss_pkg::ST_WAKING1: begin
            if (dwellDone && suppliesGood) begin
               stateNext = pss_pkg::ST_WAKING2;
            end
         end
         pss_pkg::ST_WAKING2: begin
            if (dwellDone && suppliesGood) begin
               stateNext = pss_pkg::ST_AWAKE_WAIT;
            end
         end
         pss_pkg::ST_AWAKE_WAIT: begin
            if (suppliesGood) begin
               stateNext = pss_pkg::ST_AWAKE;
            end
         end
         pss_pkg::ST_AWAKE: begin
            if (sleepReqS) begin
               stateNext = pss_pkg::ST_SLEEP1;
            end
         end
         pss_pkg::ST_SLEEP1: begin
            if (dwellDone) begin
               stateNext = pss_pkg::ST_SLEEP2;
            end
         end
         pss_pkg::ST_SLEEP2: begin
            if (dwellDone) begin
               stateNext = pss_pkg::ST_ASLEEP;
            end
         end
         default: stateNext = pss_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stateReg <= pss_pkg::ST_RESET;
      end else begin
         stateReg <= stateNext;
      end
   end

   pss_dwell_timer #(
      .CW(CW),
      .LW(pss_pkg::DWELL_W)
   ) u_dwell (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .restart(restart),
      .log2Cycles(dwellLog2),
      .expired(dwellDone)
   );

   // Registered from the next state so outputs change with the state itself
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfgOut_reg <= pss_pkg::RESET_CFG;
      end else begin
         cfgOut_reg <= nextCfg & pss_pkg::OUT_MASK;
      end
   end

   assign coreConvEnable = cfgOut_reg[pss_pkg::CORE_EN_BIT];
   assign analogConvEnable = cfgOut_reg[pss_pkg::ANA_EN_BIT];
   assign coreConvPfm = cfgOut_reg[pss_pkg::CORE_PFM_BIT];
   assign analogConvPfm = cfgOut_reg[pss_pkg::ANA_PFM_BIT];
   assign ioSupplyEnable = cfgOut_reg[pss_pkg::IO_EN_BIT];
   assign pllRegEnable = cfgOut_reg[pss_pkg::PLL_EN_BIT];
   assign tileClockGate = cfgOut_reg[pss_pkg::TILE_GATE_BIT];
   assign seqState = 3'(stateReg);

   // ****************************************
   // Assertions
   // ****************************************
   logic [CW:0] resCnt_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n || restart) begin
         resCnt_reg <= '0;
      end else begin
         resCnt_reg <= resCnt_reg + (CW+1)'(1);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_awake_apply: assert property (
      stateReg == pss_pkg::ST_AWAKE && $stable(awakeCfg_reg) |->
      coreConvEnable == awakeCfg_reg[pss_pkg::CORE_EN_BIT] &&
      ioSupplyEnable == awakeCfg_reg[pss_pkg::IO_EN_BIT] &&
      pllRegEnable == awakeCfg_reg[pss_pkg::PLL_EN_BIT])
      else $error("awake outputs differ from awake register");

   a_sleep1_apply: assert property (
      stateReg == pss_pkg::ST_SLEEP1 && $stable(sleep1Cfg_reg) |->
      tileClockGate == sleep1Cfg_reg[pss_pkg::TILE_GATE_BIT] &&
      coreConvPfm == sleep1Cfg_reg[pss_pkg::CORE_PFM_BIT] &&
      analogConvPfm == sleep1Cfg_reg[pss_pkg::ANA_PFM_BIT])
      else $error("first sleep outputs differ from its register");

   a_sleep2_apply: assert property (
      stateReg == pss_pkg::ST_SLEEP2 && $stable(sleep2Cfg_reg) |->
      coreConvEnable == sleep2Cfg_reg[pss_pkg::CORE_EN_BIT] &&
      ioSupplyEnable == sleep2Cfg_reg[pss_pkg::IO_EN_BIT] &&
      tileClockGate == sleep2Cfg_reg[pss_pkg::TILE_GATE_BIT])
      else $error("second sleep outputs differ from its register");

   a_dwell_length: assert property (
      stateReg == pss_pkg::ST_SLEEP1 && restart && $stable(sleep1Cfg_reg) |->
      resCnt_reg + (CW+1)'(1) ==
      ((CW+1)'(1) << sleep1Cfg_reg[pss_pkg::DWELL_LSB +: pss_pkg::DWELL_W]))
      else $error("first sleep dwell length wrong");

   a_dwell_short: assert property (
      stateReg == pss_pkg::ST_SLEEP2 && dwellLog2 == 5'h0 && $stable(sleep2Cfg_reg) |->
      ##1 stateReg == pss_pkg::ST_ASLEEP)
      else $error("code zero dwell did not last one cycle");

   a_clock_gate: assert property (
      stateReg == pss_pkg::ST_AWAKE && $stable(awakeCfg_reg) |->
      tileClockGate == awakeCfg_reg[pss_pkg::TILE_GATE_BIT] &&
      coreConvPfm == awakeCfg_reg[pss_pkg::CORE_PFM_BIT] &&
      analogConvPfm == awakeCfg_reg[pss_pkg::ANA_PFM_BIT])
      else $error("clock gate or modulation wrong in awake");

   a_ro_bit_one: assert property (
      pready && !pwrite && !pslverr && paddr != pss_pkg::STATUS_OFS |->
      prdata[pss_pkg::ANA_EN_BIT] && prdata[31:21] == 11'h0)
      else $error("read-only enable or reserved bits read wrong");

   a_analog_on: assert property (
      stateReg inside {pss_pkg::ST_AWAKE, pss_pkg::ST_SLEEP1, pss_pkg::ST_SLEEP2}
      |-> analogConvEnable)
      else $error("analogue converter off in a configured state");

   a_wake_good: assert property (
      stateReg == pss_pkg::ST_WAKING2 && stateNext != stateReg |->
      dwellDone && (!pllRegEnable || pllGoodS) && (!coreConvEnable || coreGoodS))
      else $error("waking advanced without good supplies");

   a_state_code: assert property (
      $rose(seqState == 3'h6) |-> $past(seqState) == 3'h5 ##1 analogConvEnable)
      else $error("sleep entry code sequence wrong");

   a_awake_holds: assert property (
      stateReg == pss_pkg::ST_AWAKE && !sleepReqS |=> stateReg == pss_pkg::ST_AWAKE)
      else $error("awake left without sleep request");

   a_io_pll: assert property (
      stateReg == pss_pkg::ST_SLEEP1 && $stable(sleep1Cfg_reg) |->
      ioSupplyEnable == sleep1Cfg_reg[pss_pkg::IO_EN_BIT] &&
      pllRegEnable == sleep1Cfg_reg[pss_pkg::PLL_EN_BIT])
      else $error("io or pll enable wrong in first sleep");

   a_core_default: assert property (
      $rose(rst_n) |-> awakeCfg_reg[pss_pkg::CORE_EN_BIT] &&
      !sleep1Cfg_reg[pss_pkg::CORE_EN_BIT] && !sleep2Cfg_reg[pss_pkg::CORE_EN_BIT])
      else $error("core converter defaults wrong");

   c_sleep_entry: cover property (
      stateReg == pss_pkg::ST_AWAKE ##1 stateReg == pss_pkg::ST_SLEEP1);
   c_reach_asleep: cover property (
      stateReg == pss_pkg::ST_SLEEP2 ##1 stateReg == pss_pkg::ST_ASLEEP);
   c_rewake: cover property (
      stateReg == pss_pkg::ST_AWAKE_WAIT ##1 stateReg == pss_pkg::ST_AWAKE);
   c_bad_addr: cover property (pready && pslverr);

endmodule : pss_supply_config
